//--- inc/sgs_defines.svh
// Purpose: Constants for the servo gain switching block
// Assumes: Included by bare name, guarded against double inclusion
// Notes: Offsets are Wishbone byte addresses
`ifndef SGS_DEFINES_SVH
`define SGS_DEFINES_SVH

// ----------------------------------------
// Sizes and timing
// ----------------------------------------
`define SGS_GW 16
`define SGS_NG 7
`define SGS_CLK_HZ 20000000
`define SGS_TICK_MS 1
`define SGS_TICK_CYCLES ((`SGS_CLK_HZ / 1000) * `SGS_TICK_MS)

// ----------------------------------------
// Mode field positions and codes
// ----------------------------------------
`define SGS_MODE_METHOD_LSB 0
`define SGS_MODE_COND_LSB 4
`define SGS_METHOD_MANUAL 4'h0
`define SGS_METHOD_AUTO1 4'h2

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SGS_ADR_MODE 8'h00
`define SGS_ADR_STATUS 8'h04
`define SGS_ADR_WAIT_TO2 8'h08
`define SGS_ADR_WAIT_TO1 8'h0C
`define SGS_ADR_RAMP_TO2 8'h10
`define SGS_ADR_RAMP_TO1 8'h14
`define SGS_ADR_GAIN_A 8'h20
`define SGS_ADR_GAIN_B 8'h40
`define SGS_ADR_APPLIED 8'h60

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SGS_RST_MODE 16'h0000
`define SGS_RST_TIME 16'h0000
`define SGS_RST_SPEED_GAIN 16'd400
`define SGS_RST_INTEG_TIME 16'd2000
`define SGS_RST_POS_GAIN 16'd400
`define SGS_RST_TRQ_FILT 16'd100
`define SGS_RST_MF_GAIN 16'd500
`define SGS_RST_MF_CORR 16'd1000
`define SGS_RST_FRIC_GAIN 16'd100

// Gain lane indices
`define SGS_IDX_POS_GAIN 2
`define SGS_IDX_MF_GAIN 4
`define SGS_IDX_MF_CORR 5

`endif

//--- inc/sgs_pkg.sv
// Purpose: Types for the servo gain switching block
// Assumes: sgs_defines.svh on the include path
// Notes: Whole module state is one packed struct
`default_nettype none
`include "sgs_defines.svh"

package sgs_pkg;

   typedef enum logic [1:0] {
      SGS_IDLE = 2'b00,
      SGS_WAIT = 2'b01,
      SGS_RAMP = 2'b10
   } sgs_state_t;

   typedef logic [`SGS_NG-1:0][`SGS_GW-1:0] sgs_gains_t;

   typedef struct packed {
      logic [15:0] mode;
      logic [15:0] wait2;
      logic [15:0] wait1;
      logic [15:0] ramp2;
      logic [15:0] ramp1;
      sgs_gains_t gain_a;
      sgs_gains_t gain_b;
      sgs_gains_t applied;
      sgs_gains_t start;
      sgs_state_t state;
      logic cur;
      logic tgt;
      logic [15:0] cnt;
      logic ack;
      logic [31:0] rdat;
   } sgs_regs_t;

endpackage : sgs_pkg

`default_nettype wire

//--- hw/sgs_tick.sv
// Purpose: Millisecond time base from the control clock
// Assumes: Single clock, asynchronous active-low reset
// Notes: Emits a one-cycle pulse every P_CYCLES clocks
`timescale 1ns/1ps
`default_nettype none

module sgs_tick #(
   parameter int unsigned P_CYCLES = 20000
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Tick
   output logic o_tick
);

   localparam int unsigned CW = $clog2(P_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(P_CYCLES - 1);

   logic [CW-1:0] cnt_ff;
   logic tick_ff;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= (cnt_ff == LAST);
         cnt_ff <= (cnt_ff == LAST) ? '0 : cnt_ff + CW'(1);
      end
   end

   assign o_tick = tick_ff;

endmodule : sgs_tick

`default_nettype wire

//--- hw/sgs_ramp.sv
// Purpose: Linear interpolation of one gain lane
// Assumes: i_num never exceeds i_den while ramping
// Notes: Combinational; caller registers the result
`timescale 1ns/1ps
`default_nettype none

module sgs_ramp #(
   parameter int unsigned P_W = 16
) (
   // Endpoints
   input wire logic [P_W-1:0] i_start,
   input wire logic [P_W-1:0] i_target,
   // Elapsed and total ticks
   input wire logic [15:0] i_num,
   input wire logic [15:0] i_den,
   // Result
   output logic [P_W-1:0] o_value
);

   logic signed [P_W:0] diff;
   logic signed [P_W+17:0] prod;
   logic signed [P_W+17:0] quo;
   logic signed [P_W+17:0] sum;

   always_comb begin
      diff = $signed({1'b0, i_target}) - $signed({1'b0, i_start});
      prod = (P_W+18)'(diff * $signed({1'b0, i_num}));
      // Truncating divide keeps the value between the endpoints
      quo = (i_den == 16'h0000) ? '0 : prod / $signed({{(P_W+2){1'b0}}, i_den});
      sum = $signed({18'h0_0000, i_start}) + quo;
      o_value = (i_den == 16'h0000) ? i_target : sum[P_W-1:0];
   end

endmodule : sgs_ramp

`default_nettype wire

//--- hw/sgs_gain_switch.sv
// Purpose: Gain set selection with manual and automatic switching
// Assumes: Loop status inputs come from logic on i_clk; Wishbone classic slave
// Notes: Applied gains are registered and also readable over the bus
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sgs_defines.svh"

module sgs_gain_switch import sgs_pkg::*; #(
   parameter int unsigned P_TICK_CYCLES = `SGS_TICK_CYCLES
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Command and loop status
   input wire logic i_gain_sel,
   input wire logic i_pos_ctrl,
   input wire logic i_positioning_complete_flag,
   input wire logic i_near_flag,
   input wire logic i_ref_filter_zero,
   input wire logic i_ref_input_on,
   input wire logic i_motion_ref,
   input wire logic i_motor_stopped,
   // Applied gains
   output logic [15:0] o_speed_loop_gain,
   output logic [15:0] o_speed_integral_time,
   output logic [15:0] o_position_loop_gain,
   output logic [15:0] o_torque_filter_time,
   output logic [15:0] o_model_follow_gain,
   output logic [15:0] o_model_follow_correction,
   output logic [15:0] o_friction_comp_gain,
   output logic o_active_set2,
   output logic o_switching
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   localparam sgs_gains_t GAIN_RST = {`SGS_RST_FRIC_GAIN, `SGS_RST_MF_CORR, `SGS_RST_MF_GAIN,
      `SGS_RST_TRQ_FILT, `SGS_RST_POS_GAIN, `SGS_RST_INTEG_TIME, `SGS_RST_SPEED_GAIN};

   sgs_regs_t st_ff;
   sgs_regs_t nxt_st;
   logic tick;
   logic [3:0] method;
   logic [3:0] cond_code;
   logic man_m;
   logic auto_m;
   logic cond_a;
   logic [15:0] wait_sel;
   logic [15:0] ramp_sel;
   logic mf_ok;
   logic wb_req;
   logic [5:0] lane_idx;
   logic lane_hit;
   sgs_gains_t ramp_val;
   sgs_gains_t tgt_val;
   sgs_gains_t sel_val;
   sgs_gains_t fix_val;

   // ----------------------------------------
   // Time base and ramp lanes
   // ----------------------------------------
   sgs_tick #(
      .P_CYCLES(P_TICK_CYCLES)
   ) u_tick (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .o_tick(tick)
   );

   for (genvar g = 0; g < `SGS_NG; g++) begin : g_lane
      assign tgt_val[g] = st_ff.tgt ? st_ff.gain_b[g] : st_ff.gain_a[g];
      assign sel_val[g] = i_gain_sel ? st_ff.gain_b[g] : st_ff.gain_a[g];
      assign fix_val[g] = cond_code[0] ? st_ff.gain_b[g] : st_ff.gain_a[g];
      sgs_ramp #(
         .P_W(`SGS_GW)
      ) u_ramp (
         .i_start(st_ff.start[g]),
         .i_target(tgt_val[g]),
         .i_num(st_ff.cnt),
         .i_den(ramp_sel),
         .o_value(ramp_val[g])
      );
   end

   // ----------------------------------------
   // Mode decode and condition A
   // ----------------------------------------
   function automatic logic [15:0] wr16(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
      logic [15:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = d[7:0];
      end
      if (be[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction : wr16

   always_comb begin
      method = st_ff.mode[`SGS_MODE_METHOD_LSB +: 4];
      cond_code = st_ff.mode[`SGS_MODE_COND_LSB +: 4];
      man_m = (method == `SGS_METHOD_MANUAL);
      auto_m = (method == `SGS_METHOD_AUTO1);
      case (cond_code)
         4'h0: cond_a = i_positioning_complete_flag;
         4'h1: cond_a = !i_positioning_complete_flag;
         4'h2: cond_a = i_near_flag;
         4'h3: cond_a = !i_near_flag;
         4'h4: cond_a = i_ref_filter_zero && !i_ref_input_on;
         4'h5: cond_a = i_ref_input_on;
         default: cond_a = i_positioning_complete_flag;
      endcase
      // Time fields are named after the set they lead to
      wait_sel = st_ff.tgt ? st_ff.wait2 : st_ff.wait1;
      ramp_sel = st_ff.tgt ? st_ff.ramp2 : st_ff.ramp1;
      mf_ok = !i_motion_ref && i_motor_stopped;
      wb_req = i_wb_cyc && i_wb_stb && !st_ff.ack;
      lane_idx = i_wb_adr[7:2] - 6'(`SGS_ADR_GAIN_A >> 2);
      lane_hit = (i_wb_adr[1:0] == 2'b00);
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.ack = wb_req;
      // Speed loop structure has no effect on any path below
      if (man_m) begin
         nxt_st.state = SGS_IDLE;
         nxt_st.cur = i_gain_sel;
         nxt_st.tgt = i_gain_sel;
         nxt_st.cnt = 16'h0000;
         for (int i = 0; i < `SGS_NG; i++) begin
            if ((i != `SGS_IDX_MF_GAIN && i != `SGS_IDX_MF_CORR) || mf_ok) begin
               nxt_st.applied[i] = sel_val[i];
            end
         end
      end else if (auto_m && !i_pos_ctrl) begin
         nxt_st.state = SGS_IDLE;
         nxt_st.cur = cond_code[0];
         nxt_st.tgt = cond_code[0];
         nxt_st.cnt = 16'h0000;
         for (int i = 0; i < `SGS_NG; i++) begin
            if (i != `SGS_IDX_MF_GAIN && i != `SGS_IDX_MF_CORR) begin
               nxt_st.applied[i] = fix_val[i];
            end
         end
      end else if (auto_m) begin
         if ((st_ff.state == SGS_IDLE) ? (cond_a != st_ff.cur) : (cond_a != st_ff.tgt)) begin
            // Restart keeps the gains where they are now
            nxt_st.tgt = cond_a;
            nxt_st.state = SGS_WAIT;
            nxt_st.cnt = 16'h0000;
            nxt_st.start = st_ff.applied;
         end else begin
            case (st_ff.state)
               SGS_IDLE: begin
                  for (int i = 0; i < `SGS_NG; i++) begin
                     if (i != `SGS_IDX_MF_GAIN && i != `SGS_IDX_MF_CORR) begin
                        nxt_st.applied[i] = st_ff.cur ? st_ff.gain_b[i] : st_ff.gain_a[i];
                     end
                  end
               end
               SGS_WAIT: begin
                  if (st_ff.cnt >= wait_sel) begin
                     nxt_st.state = SGS_RAMP;
                     nxt_st.cnt = 16'h0000;
                  end else if (tick) begin
                     nxt_st.cnt = st_ff.cnt + 16'h0001;
                  end
               end
               SGS_RAMP: begin
                  for (int i = 0; i < `SGS_NG; i++) begin
                     if (i != `SGS_IDX_MF_GAIN && i != `SGS_IDX_MF_CORR) begin
                        nxt_st.applied[i] = (st_ff.cnt >= ramp_sel) ? tgt_val[i] : ramp_val[i];
                     end
                  end
                  if (st_ff.cnt >= ramp_sel) begin
                     nxt_st.state = SGS_IDLE;
                     nxt_st.cur = st_ff.tgt;
                     nxt_st.cnt = 16'h0000;
                  end else if (tick) begin
                     nxt_st.cnt = st_ff.cnt + 16'h0001;
                  end
               end
               default: begin
                  nxt_st.state = SGS_IDLE;
               end
            endcase
         end
      end
      // Register writes and reads; unmapped reads return zero, writes are dropped
      nxt_st.rdat = 32'h0000_0000;
      if (wb_req && i_wb_we) begin
         case (i_wb_adr)
            `SGS_ADR_MODE: nxt_st.mode = wr16(st_ff.mode, i_wb_dat, i_wb_sel);
            `SGS_ADR_WAIT_TO2: nxt_st.wait2 = wr16(st_ff.wait2, i_wb_dat, i_wb_sel);
            `SGS_ADR_WAIT_TO1: nxt_st.wait1 = wr16(st_ff.wait1, i_wb_dat, i_wb_sel);
            `SGS_ADR_RAMP_TO2: nxt_st.ramp2 = wr16(st_ff.ramp2, i_wb_dat, i_wb_sel);
            `SGS_ADR_RAMP_TO1: nxt_st.ramp1 = wr16(st_ff.ramp1, i_wb_dat, i_wb_sel);
            default: begin
               if (lane_hit && lane_idx < 6'(`SGS_NG)) begin
                  nxt_st.gain_a[lane_idx[2:0]] = wr16(st_ff.gain_a[lane_idx[2:0]], i_wb_dat,
                                                      i_wb_sel);
               end else if (lane_hit && lane_idx >= 6'h08 && lane_idx < 6'(8 + `SGS_NG)) begin
                  nxt_st.gain_b[lane_idx[2:0]] = wr16(st_ff.gain_b[lane_idx[2:0]], i_wb_dat,
                                                      i_wb_sel);
               end
            end
         endcase
      end else if (wb_req) begin
         case (i_wb_adr)
            `SGS_ADR_MODE: nxt_st.rdat = {16'h0000, st_ff.mode};
            `SGS_ADR_STATUS: nxt_st.rdat = {27'h000_0000, auto_m && i_pos_ctrl,
                                            st_ff.state, st_ff.tgt, st_ff.cur};
            `SGS_ADR_WAIT_TO2: nxt_st.rdat = {16'h0000, st_ff.wait2};
            `SGS_ADR_WAIT_TO1: nxt_st.rdat = {16'h0000, st_ff.wait1};
            `SGS_ADR_RAMP_TO2: nxt_st.rdat = {16'h0000, st_ff.ramp2};
            `SGS_ADR_RAMP_TO1: nxt_st.rdat = {16'h0000, st_ff.ramp1};
            default: begin
               if (lane_hit && lane_idx < 6'(`SGS_NG)) begin
                  nxt_st.rdat = {16'h0000, st_ff.gain_a[lane_idx[2:0]]};
               end else if (lane_hit && lane_idx >= 6'h08 && lane_idx < 6'(8 + `SGS_NG)) begin
                  nxt_st.rdat = {16'h0000, st_ff.gain_b[lane_idx[2:0]]};
               end else if (lane_hit && lane_idx >= 6'h10 && lane_idx < 6'(16 + `SGS_NG)) begin
                  nxt_st.rdat = {16'h0000, st_ff.applied[lane_idx[2:0]]};
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_ff <= '{mode: `SGS_RST_MODE, wait2: `SGS_RST_TIME, wait1: `SGS_RST_TIME,
                    ramp2: `SGS_RST_TIME, ramp1: `SGS_RST_TIME, gain_a: GAIN_RST,
                    gain_b: GAIN_RST, applied: GAIN_RST, start: GAIN_RST, state: SGS_IDLE,
                    cur: 1'b0, tgt: 1'b0, cnt: 16'h0000, ack: 1'b0, rdat: 32'h0000_0000};
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_wb_ack = st_ff.ack;
   assign o_wb_dat = st_ff.rdat;
   assign o_speed_loop_gain = st_ff.applied[0];
   assign o_speed_integral_time = st_ff.applied[1];
   assign o_position_loop_gain = st_ff.applied[2];
   assign o_torque_filter_time = st_ff.applied[3];
   assign o_model_follow_gain = st_ff.applied[4];
   assign o_model_follow_correction = st_ff.applied[5];
   assign o_friction_comp_gain = st_ff.applied[6];
   assign o_active_set2 = st_ff.cur;
   assign o_switching = (st_ff.state != SGS_IDLE);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_manual_select;
      @(posedge i_clk) disable iff (!i_rst_b)
      man_m |=> (st_ff.applied[0] == $past(sel_val[0])) && (st_ff.cur == $past(i_gain_sel));
   endproperty
   a_manual_select: assert property (p_manual_select) else $error("manual select wrong");

   property p_auto_only_pos;
      @(posedge i_clk) disable iff (!i_rst_b)
      (auto_m && !i_pos_ctrl) |=> (st_ff.state == SGS_IDLE) && !o_switching;
   endproperty
   a_auto_only_pos: assert property (p_auto_only_pos) else $error("switching outside pos");

   property p_mf_hold_auto;
      @(posedge i_clk) disable iff (!i_rst_b)
      auto_m ##1 auto_m |-> $stable(o_model_follow_gain) && $stable(o_model_follow_correction);
   endproperty
   a_mf_hold_auto: assert property (p_mf_hold_auto) else $error("auto changed model gain");

   property p_mf_hold_moving;
      @(posedge i_clk) disable iff (!i_rst_b)
      (man_m && !mf_ok) |=> (o_model_follow_gain == $past(o_model_follow_gain));
   endproperty
   a_mf_hold_moving: assert property (p_mf_hold_moving) else $error("model gain moved");

   property p_to_set2;
      @(posedge i_clk) disable iff (!i_rst_b)
      (auto_m && i_pos_ctrl && st_ff.state == SGS_IDLE && !st_ff.cur && cond_a)
         |=> (st_ff.state == SGS_WAIT) && st_ff.tgt && (st_ff.cnt == 16'h0000);
   endproperty
   a_to_set2: assert property (p_to_set2) else $error("no move to set 2");

   property p_to_set1;
      @(posedge i_clk) disable iff (!i_rst_b)
      (auto_m && i_pos_ctrl && st_ff.state == SGS_IDLE && st_ff.cur && !cond_a)
         |=> (st_ff.state == SGS_WAIT) && !st_ff.tgt;
   endproperty
   a_to_set1: assert property (p_to_set1) else $error("no move to set 1");

   property p_ramp_end;
      @(posedge i_clk) disable iff (!i_rst_b)
      (auto_m && i_pos_ctrl && st_ff.state == SGS_RAMP && st_ff.cnt >= ramp_sel
         && cond_a == st_ff.tgt)
         |=> (o_position_loop_gain == $past(tgt_val[`SGS_IDX_POS_GAIN]))
             && (st_ff.state == SGS_IDLE) && (st_ff.cur == $past(st_ff.tgt));
   endproperty
   a_ramp_end: assert property (p_ramp_end) else $error("ramp end value wrong");

   property p_fixed_set;
      @(posedge i_clk) disable iff (!i_rst_b)
      (auto_m && !i_pos_ctrl) |=> (o_active_set2 == $past(cond_code[0]))
         && (o_position_loop_gain == $past(fix_val[`SGS_IDX_POS_GAIN]));
   endproperty
   a_fixed_set: assert property (p_fixed_set) else $error("fixed set wrong");

   property p_restart;
      @(posedge i_clk) disable iff (!i_rst_b)
      (auto_m && i_pos_ctrl && st_ff.state != SGS_IDLE && cond_a != st_ff.tgt)
         |=> (st_ff.state == SGS_WAIT) && (st_ff.start == $past(st_ff.applied));
   endproperty
   a_restart: assert property (p_restart) else $error("restart lost");

   property p_zero_wait;
      @(posedge i_clk) disable iff (!i_rst_b)
      (auto_m && i_pos_ctrl && st_ff.state == SGS_WAIT && cond_a == st_ff.tgt
         && wait_sel == 16'h0000) |=> (st_ff.state == SGS_RAMP);
   endproperty
   a_zero_wait: assert property (p_zero_wait) else $error("zero wait delayed");

endmodule : sgs_gain_switch

`default_nettype wire

//--- bench/sgs_host_model.sv
// Purpose: Command side model: gain select and loop status lines
// Assumes: Bench sets i_cmd right after a rising edge
// Notes: Lines are registered, so they lag the command by one clock
`timescale 1ns/1ps
`default_nettype none

module sgs_host_model (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // Command from the bench
   input wire logic [7:0] i_cmd,
   // Status and select lines
   output logic o_gain_sel,
   output logic o_pos_ctrl,
   output logic o_positioning_complete_flag,
   output logic o_near,
   output logic o_filt_zero,
   output logic o_ref_in,
   output logic o_motion_ref,
   output logic o_stopped
);
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         {o_stopped, o_motion_ref, o_ref_in, o_filt_zero} <= 4'h8;
         {o_near, o_positioning_complete_flag, o_pos_ctrl, o_gain_sel} <= 4'h0;
      end else begin
         // Select bit travels with the rest of the command word
         {o_stopped, o_motion_ref, o_ref_in, o_filt_zero} <= i_cmd[7:4];
         {o_near, o_positioning_complete_flag, o_pos_ctrl, o_gain_sel} <= i_cmd[3:0];
      end
   end
endmodule : sgs_host_model

`default_nettype wire

//--- bench/sgs_gain_switch_tb.sv
// Purpose: Self-checking bench for gain set selection
// Assumes: Tick shortened to 4 clocks
// Notes: Mode digits 2 and 3 are never written, they are reserved
`timescale 1ns/1ps
`default_nettype none

module sgs_gain_switch_tb;
   logic clk, rst_b, cyc, stb, we, ack, act2, swi;
   logic [7:0] adr, cmd;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, q;
   logic gs, pc, pcf, near, fz, rin, mref, stp;
   logic [15:0] spd, integ, posg, trq, mfg, mfc, fric;
   logic [7:0] t_on [6] = '{8'h04, 8'h00, 8'h08, 8'h00, 8'h10, 8'h20};
   logic [7:0] t_off [6] = '{8'h00, 8'h04, 8'h00, 8'h08, 8'h00, 8'h00};
   int n_fail, checks_done;

   sgs_host_model i_host (.i_clk(clk), .i_rst_b(rst_b), .i_cmd(cmd), .o_gain_sel(gs),
      .o_pos_ctrl(pc), .o_positioning_complete_flag(pcf), .o_near(near), .o_filt_zero(fz),
      .o_ref_in(rin),
      .o_motion_ref(mref), .o_stopped(stp));

   sgs_gain_switch #(.P_TICK_CYCLES(4)) i_dut (.i_clk(clk), .i_rst_b(rst_b),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_gain_sel(gs), .i_pos_ctrl(pc),
      .i_positioning_complete_flag(pcf), .i_near_flag(near), .i_ref_filter_zero(fz),
      .i_ref_input_on(rin), .i_motion_ref(mref), .i_motor_stopped(stp),
      .o_speed_loop_gain(spd), .o_speed_integral_time(integ), .o_position_loop_gain(posg),
      .o_torque_filter_time(trq), .o_model_follow_gain(mfg), .o_model_follow_correction(mfc),
      .o_friction_comp_gain(fric), .o_active_set2(act2), .o_switching(swi));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic close_out();
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, got);
      end
   endtask : chk

   // Classic single cycle; ack is awaited, never assumed
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      int i;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (ack !== 1'b1 && i < 50);
      r = rdat;
      cyc <= 1'b0; stb <= 1'b0;
      if (i >= 50) begin
         n_fail++;
         close_out();
      end
   endtask : wb

   task automatic wait_gain(input logic [15:0] exp);
      int i;
      for (i = 0; i < 400 && spd !== exp; i++) @(posedge clk);
      if (i >= 400) begin
         n_fail++;
         close_out();
      end
      chk("speed gain", exp, spd);
   endtask : wait_gain

   initial begin
      rst_b = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
      wdat = 32'h0000_0000; cmd = 8'h80; n_fail = 0; checks_done = 0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk("speed rst", 400, spd);
      chk("mf gain rst", 500, mfg);
      chk("set2 rst", 0, act2);
      chk("integ rst", 2000, integ);
      chk("pos gain rst", 400, posg);
      chk("trq filt rst", 100, trq);
      chk("mf corr rst", 1000, mfc);
      chk("fric rst", 100, fric);
      chk("switching rst", 0, swi);
      wb(1'b0, 8'h08, 0, q); chk("wait rst", 0, q);
      wb(1'b0, 8'h18, 0, q); chk("unmapped", 0, q);
      wb(1'b1, 8'h40, 32'h0000_0100, q);
      wb(1'b1, 8'h50, 32'h0000_0300, q);
      wb(1'b1, 8'h48, 32'h0000_0200, q);
      wb(1'b1, 8'h54, 32'h0000_0400, q);
      wb(1'b1, 8'h60, 32'h0000_1234, q);
      chk("applied ro", 400, spd);
      // Manual: select high, motor stopped, no reference
      cmd <= 8'h81;
      wait_gain(16'h0100);
      repeat (3) @(posedge clk);
      chk("mf gain sel", 16'h0300, mfg);
      chk("pos gain sel", 16'h0200, posg);
      chk("mf corr sel", 16'h0400, mfc);
      cmd <= 8'hC0;
      wait_gain(400);
      repeat (3) @(posedge clk);
      chk("mf gain hold", 16'h0300, mfg);
      chk("mf corr hold", 16'h0400, mfc);
      cmd <= 8'h80;
      repeat (4) @(posedge clk);
      chk("mf gain back", 500, mfg);
      chk("mf corr back", 1000, mfc);
      wb(1'b1, 8'h08, 2, q);
      wb(1'b1, 8'h10, 4, q);
      wb(1'b1, 8'h00, 32'h0000_0002, q);
      cmd <= 8'h82;
      repeat (4) @(posedge clk);
      chk("auto idle", 400, spd);
      cmd <= 8'h86;
      for (int i = 0; i < 400 && spd === 400; i++) @(posedge clk);
      chk("ramp mid", 1, spd > 256 && spd < 400);
      chk("switching", 1, swi);
      wait_gain(16'h0100);
      repeat (2) @(posedge clk);
      chk("set2 flag", 1, act2);
      chk("mf gain auto", 500, mfg);
      chk("mf corr auto", 1000, mfc);
      chk("pos gain auto", 16'h0200, posg);
      chk("switching end", 0, swi);
      cmd <= 8'h82;
      wait_gain(400);
      cmd <= 8'h86;
      repeat (6) @(posedge clk);
      cmd <= 8'h82;
      q = 32'h0000_0000;
      repeat (60) begin
         @(posedge clk);
         q[0] = q[0] | act2;
      end
      chk("restart no set2", 0, q);
      chk("restart", 400, spd);
      wb(1'b1, 8'h08, 0, q);
      wb(1'b1, 8'h10, 0, q);
      for (int c = 0; c < 6; c++) begin
         wb(1'b1, 8'h00, {24'h0, 4'(c), 4'h2}, q);
         cmd <= 8'h82 | t_on[c];
         wait_gain(16'h0100);
         cmd <= 8'h82 | t_off[c];
         wait_gain(400);
         cmd <= 8'h80 | t_on[c];
         wait_gain(c[0] ? 16'h0100 : 16'd400);
         cmd <= 8'h82 | t_on[c];
         wait_gain(16'h0100);
         cmd <= 8'h80 | t_on[c];
         wait_gain(c[0] ? 16'h0100 : 16'd400);
      end
      close_out();
   end
endmodule : sgs_gain_switch_tb

`default_nettype wire
